// >>> acs_cpu_model.sv
// behavioural cpu core: sleeps on command, wakes on converter or other interrupt
`timescale 1ns/10ps
module acs_cpu_model
(
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_sleep_go,
  input  wire logic i_other_irq,
  input  wire logic i_wake,
  output logic      o_halted,
  output logic      o_irq_ack
);
  always_ff @(posedge i_clock or posedge i_rst)
    if (i_rst)
    begin
      o_halted  <= 1'b0;
      o_irq_ack <= 1'b0;
    end
    else
    begin
      // woken by the converter, the vector runs at once and acknowledges
      o_irq_ack <= i_wake;
      if (i_sleep_go)
        o_halted <= 1'b1;
      else if (i_wake || i_other_irq)
        o_halted <= 1'b0;
    end
endmodule

// >>> acs_ctrl.sv
// control logic of the successive-approximation converter: selection buffering, start, sleep, result
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps

// Function
// - selection held in temporary register, moved safely
// - idle and enabled: working selection follows temporary every cycle
// - conversion start freezes working selection
// - copying resumes in last converter cycle
// - start bit begins conversion on next tick
// - safely written selection applies to next conversion
// - free running: change shows from second result
// - inputs above reference give full-scale code
// - idle or noise-reduction sleep entry starts conversion once cpu halted
// - sleep conversion end wakes the cpu
// - early wake still raises completion request
// - cpu stays active until next sleep
// - converter stays powered in other sleep modes
// - codes span zero to two-to-n minus one
// - completion writes result, sets flag, clears start unless free running
// - conversion 13 cycles, first one 25
// - reference bits 7:6, channel bits 3:0
module acs_ctrl
  import acs_pkg::*;
#(
  parameter int TRIG_SRCS = 7
)
(
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_RST,
  input  wire logic [2:0]           I_ADDR,
  input  wire logic [7:0]           I_WDATA,
  input  wire logic                 I_WR,
  input  wire logic                 I_RD,
  output logic      [7:0]           O_RDATA,
  input  wire logic [TRIG_SRCS-1:0] I_TRIGGER_SRC,
  input  wire logic [10:0]          I_ANALOG_LEVEL,
  input  wire logic                 I_CPU_HALTED,
  input  wire logic [2:0]           I_SLEEP_MODE,
  input  wire logic                 I_IRQ_ACK,
  output logic      [3:0]           O_CHANNEL_SELECT,
  output logic      [1:0]           O_REFERENCE_SELECT,
  output logic                      O_SAMPLE,
  output logic                      O_BUSY,
  output logic                      O_IRQ,
  output logic                      O_WAKE,
  output logic                      O_ANALOG_POWER
);

  acs_state_t s_r;
  acs_state_t s_nxt;

  logic [6:0] presc_term;
  logic       tick;
  logic       trig_level;
  logic       trig_edge;
  logic       locked;
  logic [4:0] conv_len;
  logic [4:0] sh_point;
  logic       sleep_entry;
  logic [9:0] level_code;

  always_comb
  begin
    // division factor 2,2,4,...,128 expressed as terminal count
    if (s_r.ps == 3'h0)
    begin
      presc_term = PRESC_MIN;
    end
    else
    begin
      presc_term = 7'((8'h01 << s_r.ps) - 8'h01);
    end
    tick = (s_r.presc == presc_term);
  end

  always_comb
  begin
    if (s_r.ts == TS_FREE_RUN)
    begin
      trig_level = 1'b0;
    end
    else
    begin
      trig_level = I_TRIGGER_SRC[s_r.ts - 3'h1];
    end
    trig_edge = trig_level & ~s_r.trig_prev;
  end

  always_comb
  begin
    conv_len = s_r.first_conv ? CONV_FIRST_CYC : CONV_NORMAL_CYC;
    sh_point = s_r.first_conv ? SH_FIRST_CYC : SH_NORMAL_CYC;
    // lock lifts in the last converter cycle of the conversion
    locked = (s_r.phase == PH_CONV) && (s_r.cnt != conv_len - 5'h01);
    sleep_entry = I_CPU_HALTED && !s_r.halted_prev &&
                  ((I_SLEEP_MODE == SLEEP_IDLE) || (I_SLEEP_MODE == SLEEP_NOISE_RED));
    // anything at or above the reference saturates at full scale
    if (I_ANALOG_LEVEL > LEVEL_MAX)
    begin
      level_code = RESULT_MAX;
    end
    else
    begin
      level_code = I_ANALOG_LEVEL[9:0];
    end
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = RESET_BYTE;
    s_nxt.wake = 1'b0;
    s_nxt.sample_stb = 1'b0;
    s_nxt.trig_prev = trig_level;
    s_nxt.halted_prev = I_CPU_HALTED;

    // prescaler runs only while enabled
    if (!s_r.en || tick)
    begin
      s_nxt.presc = 7'h00;
    end
    else
    begin
      s_nxt.presc = s_r.presc + 7'h01;
    end

    // working selection follows temporary whenever enabled and not locked
    if (s_r.en && !locked)
    begin
      s_nxt.work_ref = s_r.tmp_ref;
      s_nxt.work_ch = s_r.tmp_ch;
    end

    if (I_IRQ_ACK)
    begin
      s_nxt.flag = 1'b0;
    end

    if (I_WR)
    begin
      case (I_ADDR)
        ADDR_SEL:
        begin
          s_nxt.tmp_ref = I_WDATA[SEL_REF_HI:SEL_REF_LO];
          s_nxt.left_adj = I_WDATA[SEL_LEFT_ADJ];
          s_nxt.tmp_ch = I_WDATA[SEL_CH_HI:SEL_CH_LO];
        end
        ADDR_CTRLA:
        begin
          s_nxt.en = I_WDATA[CTA_ENABLE];
          s_nxt.ate = I_WDATA[CTA_AUTO];
          s_nxt.ie = I_WDATA[CTA_IE];
          s_nxt.ps = I_WDATA[CTA_PS_HI:CTA_PS_LO];
          // writing zero to start has no effect
          if (I_WDATA[CTA_START])
          begin
            s_nxt.start_pend = 1'b1;
          end
          if (I_WDATA[CTA_FLAG])
          begin
            s_nxt.flag = 1'b0;
          end
        end
        ADDR_CTRLB:
        begin
          s_nxt.ts = I_WDATA[CTB_TS_HI:CTB_TS_LO];
        end
        default:
        begin
          s_nxt.ts = s_r.ts;
        end
      endcase
    end

    if (I_RD)
    begin
      case (I_ADDR)
        ADDR_SEL:
        begin
          s_nxt.rdata = {s_r.tmp_ref, s_r.left_adj, 1'b0, s_r.tmp_ch};
        end
        ADDR_CTRLA:
        begin
          s_nxt.rdata = {s_r.en, s_r.start_pend, s_r.ate, s_r.flag, s_r.ie, s_r.ps};
        end
        ADDR_CTRLB:
        begin
          s_nxt.rdata = {5'h00, s_r.ts};
        end
        ADDR_RES_LO:
        begin
          // low byte read freezes the pair until the high byte is read
          s_nxt.rdata = s_r.left_adj ? {s_r.res[1:0], 6'h00} : s_r.res[7:0];
          s_nxt.res_lock = 1'b1;
        end
        ADDR_RES_HI:
        begin
          s_nxt.rdata = s_r.left_adj ? s_r.res[9:2] : {6'h00, s_r.res[9:8]};
          s_nxt.res_lock = 1'b0;
        end
        default:
        begin
          s_nxt.rdata = RESET_BYTE;
        end
      endcase
    end

    // noise canceler: conversion begins on the tick after the cpu halts
    if (sleep_entry && s_r.en && s_r.phase == PH_IDLE && !s_r.start_pend && !s_r.ate && s_r.ie)
    begin
      s_nxt.start_pend = 1'b1;
      s_nxt.sleep_conv = 1'b1;
    end

    case (s_r.phase)
      PH_IDLE:
      begin
        if (s_r.en && s_r.ate && trig_edge)
        begin
          // trigger resets the prescaler for a fixed start delay
          s_nxt.phase = PH_CONV;
          s_nxt.presc = 7'h00;
          s_nxt.cnt = 5'h00;
          s_nxt.start_pend = 1'b1;
          s_nxt.first_conv = s_r.first_pend;
          s_nxt.first_pend = 1'b0;
        end
        else if (s_r.en && s_r.start_pend && tick)
        begin
          s_nxt.phase = PH_CONV;
          s_nxt.cnt = 5'h00;
          s_nxt.first_conv = s_r.first_pend;
          s_nxt.first_pend = 1'b0;
        end
      end
      PH_CONV:
      begin
        if (tick)
        begin
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == sh_point - 5'h01)
          begin
            s_nxt.sample = level_code;
            s_nxt.sample_stb = 1'b1;
          end
          if (s_r.cnt == conv_len - 5'h01)
          begin
            // a pending low-byte read discards the result, flag still sets
            if (!s_nxt.res_lock)
            begin
              s_nxt.res = s_r.sample;
            end
            s_nxt.flag = 1'b1;
            s_nxt.cnt = 5'h00;
            s_nxt.first_conv = 1'b0;
            if (s_r.sleep_conv && I_CPU_HALTED)
            begin
              s_nxt.wake = 1'b1;
            end
            s_nxt.sleep_conv = 1'b0;
            if (s_r.ate && s_r.ts == TS_FREE_RUN)
            begin
              // restarts at once with the selection copied this cycle
              s_nxt.phase = PH_CONV;
            end
            else
            begin
              s_nxt.phase = PH_IDLE;
              s_nxt.start_pend = 1'b0;
            end
          end
        end
      end
      default:
      begin
        s_nxt.phase = PH_IDLE;
      end
    endcase

    // turning off aborts any conversion and rearms the long first one
    if (!s_nxt.en)
    begin
      s_nxt.phase = PH_IDLE;
      s_nxt.start_pend = 1'b0;
      s_nxt.sleep_conv = 1'b0;
      s_nxt.cnt = 5'h00;
      s_nxt.first_pend = 1'b1;
    end

    s_nxt.irq = s_nxt.flag & s_nxt.ie;
  end

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      s_r <= '0;
      s_r.first_pend <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign O_RDATA = s_r.rdata;
  assign O_CHANNEL_SELECT = s_r.work_ch;
  assign O_REFERENCE_SELECT = s_r.work_ref;
  assign O_SAMPLE = s_r.sample_stb;
  assign O_BUSY = s_r.start_pend;
  assign O_IRQ = s_r.irq;
  assign O_WAKE = s_r.wake;
  // power follows enable alone; sleep modes do not switch it off
  assign O_ANALOG_POWER = s_r.en;

endmodule

// >>> acs_ctrl_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module acs_ctrl_bench
  import acs_pkg::*;
;
  logic I_CLOCK = 0, I_RST = 1, I_WR = 0, I_RD = 0, sleep_go = 0, other_irq = 0;
  logic [2:0] I_ADDR = 0, I_SLEEP_MODE = 0;
  logic [7:0] I_WDATA = 0, O_RDATA;
  logic [10:0] I_ANALOG_LEVEL = 0;
  logic [3:0] O_CHANNEL_SELECT;
  logic [1:0] O_REFERENCE_SELECT;
  logic O_SAMPLE, O_BUSY, O_IRQ, O_WAKE, O_ANALOG_POWER, I_CPU_HALTED, I_IRQ_ACK;
  int failures, n_tests, n_wake, cyc, s, t, w;
  acs_ctrl i_acs_ctrl (.*, .I_TRIGGER_SRC(7'h00));
  acs_cpu_model i_acs_cpu_model (.i_clock(I_CLOCK), .i_rst(I_RST), .i_sleep_go(sleep_go),
    .i_other_irq(other_irq), .i_wake(O_WAKE), .o_halted(I_CPU_HALTED), .o_irq_ack(I_IRQ_ACK));
  task print_verdict;
    $display("failures %0d n_tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge I_CLOCK);
    I_ADDR  <= a;
    I_WDATA <= d;
    I_WR    <= 1'b1;
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge I_CLOCK);
    I_ADDR <= a;
    I_RD   <= 1'b1;
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    #1;
    check("rdata", O_RDATA, e);
  endtask
  // k: 0 start bit low, 1 sample pulse, 2 interrupt request
  task wait_ev(input int k);
    t = 0;
    while (t < 300)
    begin
      @(posedge I_CLOCK);
      #1;
      t++;
      if (k == 0 ? O_BUSY !== 1'b1 : k == 1 ? O_SAMPLE === 1'b1 : O_IRQ === 1'b1)
        break;
    end
    check("wait", 16'(t < 300), 16'h1);
  endtask
  initial
    forever #12.5 I_CLOCK = ~I_CLOCK;
  always @(posedge I_CLOCK)
  begin
    n_wake += (O_WAKE === 1'b1);
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (12) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    for (int a = 0; a < 6; a++)
      rd(a[2:0], 8'h00);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    wr(ADDR_SEL, 8'hF5);
    rd(ADDR_SEL, 8'hE5);
    check("ch_off", O_CHANNEL_SELECT, 16'h0);
    I_ANALOG_LEVEL <= 11'h5AA;
    wr(ADDR_CTRLA, 8'h88);
    wr(ADDR_CTRLA, 8'hC8);
    #1;
    s = cyc;
    repeat (4) @(posedge I_CLOCK);
    wr(ADDR_SEL, 8'h02);
    rd(ADDR_SEL, 8'h02);
    check("ch_lock", {O_REFERENCE_SELECT, O_CHANNEL_SELECT}, 16'h35);
    wait_ev(0);
    check("first_len", 16'((cyc - s) inside {[50:54]}), 16'h1);
    @(posedge I_CLOCK);
    check("ch_next", {O_REFERENCE_SELECT, O_CHANNEL_SELECT}, 16'h02);
    rd(ADDR_CTRLA, 8'h98);
    check("irq", O_IRQ, 16'h1);
    rd(ADDR_RES_LO, 8'hFF);
    rd(ADDR_RES_HI, 8'h03);
    wr(ADDR_SEL, 8'h22);
    repeat (3) @(posedge I_CLOCK);
    I_ANALOG_LEVEL <= 11'h155;
    wr(ADDR_CTRLA, 8'hD8);
    #1;
    s = cyc;
    wait_ev(0);
    check("norm_len", 16'((cyc - s) inside {[26:30]}), 16'h1);
    rd(ADDR_RES_LO, 8'h40);
    rd(ADDR_RES_HI, 8'h55);
    wr(ADDR_SEL, 8'h01);
    wr(ADDR_CTRLA, 8'hF8);
    wait_ev(2);
    wr(ADDR_SEL, 8'h07);
    wait_ev(1);
    check("fr_old", O_CHANNEL_SELECT, 16'h1);
    wait_ev(1);
    check("fr_new", O_CHANNEL_SELECT, 16'h7);
    wr(ADDR_CTRLA, 8'h00);
    for (int m = 0; m < 3; m++)
    begin
      wr(ADDR_CTRLA, 8'h98);
      @(posedge I_CLOCK);
      I_SLEEP_MODE <= m[2:0];
      sleep_go     <= 1'b1;
      @(posedge I_CLOCK);
      sleep_go <= 1'b0;
      w = n_wake;
      repeat (6) @(posedge I_CLOCK);
      other_irq <= (m > 0);
      @(posedge I_CLOCK);
      other_irq <= 1'b0;
      repeat (60) @(posedge I_CLOCK);
      #1;
      check("wake", 16'(n_wake - w), 16'(m == 0));
      check("irq", O_IRQ, 16'(m == 1));
      check("busy", O_BUSY, 16'h0);
      check("power", O_ANALOG_POWER, 16'h1);
      check("halted", I_CPU_HALTED, 16'h0);
    end
    print_verdict;
  end
endmodule
bind acs_ctrl acs_ctrl_sva i_acs_ctrl_sva (.*);

// >>> acs_ctrl_sva.sv
// concurrent checks on the ports of the converter control block
`timescale 1ns/10ps
module acs_ctrl_sva
  import acs_pkg::*;
(
  input wire logic       I_CLOCK,
  input wire logic       I_RST,
  input wire logic [2:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic       I_WR,
  input wire logic       I_RD,
  input wire logic       I_CPU_HALTED,
  input wire logic [7:0] O_RDATA,
  input wire logic [3:0] O_CHANNEL_SELECT,
  input wire logic [1:0] O_REFERENCE_SELECT,
  input wire logic       O_SAMPLE,
  input wire logic       O_BUSY,
  input wire logic       O_IRQ,
  input wire logic       O_WAKE,
  input wire logic       O_ANALOG_POWER
);
  logic       auto_r;
  logic [7:0] tmp_r;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // shadow copies; reserved bit 4 of the selection always reads zero
  always_ff @(posedge I_CLOCK or posedge I_RST)
    if (I_RST)
    begin
      auto_r <= 1'b0;
      tmp_r  <= 8'h00;
    end
    else if (I_WR && I_ADDR == ADDR_CTRLA)
      auto_r <= I_WDATA[CTA_AUTO];
    else if (I_WR && I_ADDR == ADDR_SEL)
      tmp_r <= I_WDATA & 8'hEF;
  chk_idle_copy: assert property (
    I_WR && I_ADDR == ADDR_SEL && O_ANALOG_POWER && !O_BUSY ##1 (!I_WR && !O_BUSY)[*3]
    |-> {O_REFERENCE_SELECT, O_CHANNEL_SELECT} == {$past(I_WDATA[7:6], 3), $past(I_WDATA[3:0], 3)})
    else $error("idle selection not copied");
  chk_sel_frozen: assert property (
    O_SAMPLE |=> ($stable(O_CHANNEL_SELECT) && $stable(O_REFERENCE_SELECT))[*8])
    else $error("selection moved during conversion");
  chk_conv_len: assert property (
    O_SAMPLE && !auto_r |-> ##[21:23] $fell(O_BUSY))
    else $error("sample to completion distance wrong");
  chk_irq_done: assert property (
    $rose(O_IRQ) && !auto_r |-> !O_BUSY)
    else $error("flag set while start bit still high");
  chk_rd_quiet: assert property (
    !$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read cycle");
  chk_sel_read: assert property (
    I_RD && I_ADDR == ADDR_SEL |=> O_RDATA == $past(tmp_r))
    else $error("selection readback differs");
  chk_power_hold: assert property (
    O_ANALOG_POWER && !(I_WR && I_ADDR == ADDR_CTRLA) |=> O_ANALOG_POWER)
    else $error("power dropped without a write");
  chk_start_busy: assert property (
    I_WR && I_ADDR == ADDR_CTRLA && I_WDATA[CTA_ENABLE] && I_WDATA[CTA_START] |=> O_BUSY)
    else $error("start bit not pending");
  chk_wake_halt: assert property (
    O_WAKE |-> $past(I_CPU_HALTED))
    else $error("wake while cpu running");
endmodule

// >>> acs_pkg.sv
// constants, register layout and state types of the converter control block
package acs_pkg;

  // register offsets on the plain register port
  localparam logic [2:0] ADDR_SEL    = 3'h0;
  localparam logic [2:0] ADDR_CTRLA  = 3'h1;
  localparam logic [2:0] ADDR_CTRLB  = 3'h2;
  localparam logic [2:0] ADDR_RES_LO = 3'h3;
  localparam logic [2:0] ADDR_RES_HI = 3'h4;

  // input_selection_register fields
  localparam int SEL_REF_HI   = 7;
  localparam int SEL_REF_LO   = 6;
  localparam int SEL_LEFT_ADJ = 5;
  localparam int SEL_CH_HI    = 3;
  localparam int SEL_CH_LO    = 0;

  // converter_control_register_a fields
  localparam int CTA_ENABLE = 7;
  localparam int CTA_START  = 6;
  localparam int CTA_AUTO   = 5;
  localparam int CTA_FLAG   = 4;
  localparam int CTA_IE     = 3;
  localparam int CTA_PS_HI  = 2;
  localparam int CTA_PS_LO  = 0;

  // control register b: trigger source select
  localparam int CTB_TS_HI = 2;
  localparam int CTB_TS_LO = 0;
  localparam logic [2:0] TS_FREE_RUN = 3'h0;

  // sleep mode codes seen on the sleep mode input
  localparam logic [2:0] SLEEP_IDLE      = 3'h0;
  localparam logic [2:0] SLEEP_NOISE_RED = 3'h1;

  // conversion timing in converter clock cycles
  localparam logic [4:0] CONV_NORMAL_CYC = 5'h0D;
  localparam logic [4:0] CONV_FIRST_CYC  = 5'h19;
  localparam logic [4:0] SH_NORMAL_CYC   = 5'h02;
  localparam logic [4:0] SH_FIRST_CYC    = 5'h0E;

  localparam logic [9:0]  RESULT_MAX  = 10'h3FF;
  localparam logic [10:0] LEVEL_MAX   = 11'h3FF;
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [6:0]  PRESC_MIN   = 7'h01;

  typedef enum logic {PH_IDLE, PH_CONV} acs_phase_t;

  typedef struct packed {
    logic [1:0] tmp_ref;
    logic [3:0] tmp_ch;
    logic       left_adj;
    logic       en;
    logic       ate;
    logic       flag;
    logic       ie;
    logic [2:0] ps;
    logic [2:0] ts;
    logic [1:0] work_ref;
    logic [3:0] work_ch;
    acs_phase_t phase;
    logic       start_pend;
    logic       first_pend;
    logic       first_conv;
    logic [4:0] cnt;
    logic [6:0] presc;
    logic [9:0] sample;
    logic [9:0] res;
    logic       res_lock;
    logic       trig_prev;
    logic       halted_prev;
    logic       sleep_conv;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    logic       sample_stb;
  } acs_state_t;

endpackage
